// *** bench/bsgp_pin_model.sv ***
// Pin environment model for one 8-bit port
`timescale 1ns/1ps
module bsgp_pin_model
(
    input wire logic [7:0] oe_n,
    input wire logic [7:0] out,
    input wire logic [7:0] pull,
    input wire logic [7:0] ext,
    output logic [7:0] level
);
    // Driven pins follow the device, released pins pulled or externally set
    assign level = (~oe_n & out) | (oe_n & (pull | ext));
endmodule

// *** bench/bsgp_ports_checker.sv ***
// Assertion checker for the bus-shared port block
`timescale 1ns/1ps
module bsgp_ports_checker
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [1:0] MODE,
    input wire logic EXT_CTRL_MAP_ENABLE,
    input wire logic [3:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_HIT,
    input wire logic [7:0] PIN_LOW_OE_N,
    input wire logic [7:0] PIN_LOW_PULL,
    input wire logic [7:0] PIN_HIGH_PULL,
    input wire logic [7:0] PIN_CTRL_IN,
    input wire logic [7:0] PIN_CTRL_OE_N,
    input wire logic [7:0] PIN_CTRL_PULL,
    input wire logic MASKABLE_IRQ_IN_N,
    input wire logic NONMASKABLE_IRQ_IN_N
);
    logic [1:0] cnt;
    always_ff @(posedge CLK)
    begin
        if (RESET)
            cnt <= 2'h0;
        else if (cnt != 2'h3)
            cnt <= cnt + 2'h1;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_unmapped_read_zero: assert property (REG_RD && !REG_HIT |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_bus_map_mode: assert property (REG_ADDR < 4'h4 |-> REG_HIT == (MODE == 2'h0))
        else $error("bus port map wrong");
    a_ctrl_map_mode: assert property ((REG_ADDR == 4'h8 || REG_ADDR == 4'h9) |->
        REG_HIT == (MODE == 2'h0 || (MODE != 2'h2 && !EXT_CTRL_MAP_ENABLE)))
        else $error("control port map wrong");
    a_reduce_map_mode: assert property (REG_ADDR == 4'hd |-> REG_HIT == (MODE != 2'h2))
        else $error("reduce map wrong");
    a_dir_write_drive: assert property (REG_WR && REG_HIT && REG_ADDR == 4'h2 ##1
        MODE == 2'h0 |-> PIN_LOW_OE_N == ~$past(REG_WDATA))
        else $error("direction write not applied");
    a_ctrl_low_input: assert property (PIN_CTRL_OE_N[1:0] == 2'h3)
        else $error("input-only pin driven");
    a_irq_sync_lag: assert property (cnt == 2'h3 |->
        {MASKABLE_IRQ_IN_N, NONMASKABLE_IRQ_IN_N} == $past(PIN_CTRL_IN[1:0], 2))
        else $error("interrupt input level wrong");
    a_ctrl_pull_mask: assert property ((PIN_CTRL_PULL & 8'h70) == 8'h00 &&
        (PIN_CTRL_PULL & ~PIN_CTRL_OE_N) == 8'h00)
        else $error("control pull on wrong pin");
    a_bus_pull_off: assert property (MODE != 2'h0 && $stable(MODE) |->
        (PIN_LOW_PULL | PIN_HIGH_PULL) == 8'h00)
        else $error("bus port pulled while expanded");
    c_unmapped_read: cover property (REG_RD && !REG_HIT);
    c_reduce_write: cover property (REG_WR && REG_HIT && REG_ADDR == 4'hd);
    c_ctrl_pull: cover property (PIN_CTRL_PULL != 8'h00);
endmodule
bind bsgp_ports bsgp_ports_checker i_chk (.*);

// *** bench/tb_bsgp_ports.sv ***
// Self-checking bench of the bus-shared port block
`timescale 1ns/1ps
module tb_bsgp_ports;
    logic CLK, RESET, EXT_CTRL_MAP_ENABLE, REG_WR, REG_RD, REG_HIT, BUS_DRIVE;
    logic MASKABLE_IRQ_IN_N, NONMASKABLE_IRQ_IN_N;
    logic [1:0] MODE;
    logic [3:0] REG_ADDR;
    logic [7:0] REG_WDATA, REG_RDATA, BUS_LOW_OUT, BUS_HIGH_OUT, BUS_LOW_IN, BUS_HIGH_IN;
    logic [7:0] CTRL_FUNC_OUT, CTRL_FUNC_OE_N, PIN_LOW_IN, PIN_HIGH_IN, PIN_CTRL_IN;
    logic [7:0] PIN_LOW_OUT, PIN_LOW_OE_N, PIN_LOW_PULL, PIN_LOW_WEAK;
    logic [7:0] PIN_HIGH_OUT, PIN_HIGH_OE_N, PIN_HIGH_PULL, PIN_HIGH_WEAK;
    logic [7:0] PIN_CTRL_OUT, PIN_CTRL_OE_N, PIN_CTRL_PULL, PIN_CTRL_WEAK;
    logic [7:0] xl, xh, xc, dl, dh, dc, ql, qh, qc, asg, pu, rdv, oc, o;
    logic rdw;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    bsgp_ports i_dut (.*);
    bsgp_pin_model i_ml (.oe_n(PIN_LOW_OE_N), .out(PIN_LOW_OUT), .pull(PIN_LOW_PULL),
        .ext(xl), .level(PIN_LOW_IN));
    bsgp_pin_model i_mh (.oe_n(PIN_HIGH_OE_N), .out(PIN_HIGH_OUT), .pull(PIN_HIGH_PULL),
        .ext(xh), .level(PIN_HIGH_IN));
    bsgp_pin_model i_mc (.oe_n(PIN_CTRL_OE_N), .out(PIN_CTRL_OUT), .pull(PIN_CTRL_PULL),
        .ext(xc), .level(PIN_CTRL_IN));
    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    function automatic logic [7:0] r8();
        return 8'($urandom);
    endfunction
    function automatic bit hit(input logic [3:0] a);
        if (a < 4'h4)
            return MODE == 2'h0;
        if (a == 4'h8 || a == 4'h9)
            return MODE == 2'h0 || (MODE != 2'h2 && !EXT_CTRL_MAP_ENABLE);
        if (a == 4'hd)
            return MODE != 2'h2;
        return a == 4'ha || a == 4'hc;
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge CLK);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        @(posedge CLK);
        if (hit(a))
        begin
            case (a)
                4'h0: dl = d;
                4'h1: dh = d;
                4'h2: ql = d;
                4'h3: qh = d;
                4'h8: dc = d;
                4'h9: qc = d;
                4'ha: asg = d;
                4'hc: pu = d;
                4'hd: if (!rdw) rdv = d;
                default: ;
            endcase
            if (a == 4'hd)
                rdw = 1'b1;
        end
        @(negedge CLK);
        REG_WR = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(negedge CLK);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(posedge CLK);
        @(negedge CLK);
        REG_RD = 1'b0;
        @(posedge CLK);
        @(negedge CLK);
        cmp(REG_RDATA & m, e & m);
    endtask
    task automatic rst();
        RESET = 1'b1;
        {dl, dh, dc, ql, qh, qc, asg, pu, rdv, rdw} = '0;
        repeat (8) @(negedge CLK);
        RESET = 1'b0;
    endtask
    task automatic chk();
        oc = (asg & CTRL_FUNC_OE_N) | (~asg & ~qc) | 8'h03;
        cmp(PIN_LOW_OE_N, ~ql);
        cmp(PIN_HIGH_OE_N, ~qh);
        cmp(PIN_CTRL_OE_N, oc);
        cmp(PIN_LOW_PULL, pu[0] ? ~ql : 8'h00);
        cmp(PIN_CTRL_PULL, pu[4] ? oc & 8'h8f : 8'h00);
        cmp(PIN_LOW_WEAK & ~PIN_LOW_OE_N, rdv[0] ? ql : 8'h00);
        cmp(PIN_CTRL_WEAK & ~oc, rdv[3] ? ~oc : 8'h00);
        cmp(PIN_LOW_OUT & ql, dl & ql);
        cmp(PIN_HIGH_OUT & qh, dh & qh);
        cmp(PIN_HIGH_PULL, pu[1] ? ~qh : 8'h00);
        cmp(PIN_HIGH_WEAK & ~PIN_HIGH_OE_N, rdv[1] ? qh : 8'h00);
        cmp(PIN_CTRL_OUT & ~oc, ((~asg & dc) | (asg & CTRL_FUNC_OUT)) & ~oc);
        cmp(BUS_LOW_IN, (dl & ql) | ((xl | {8{pu[0]}}) & ~ql));
        cmp(BUS_HIGH_IN, (dh & qh) | ((xh | {8{pu[1]}}) & ~qh));
    endtask
    task automatic final_report();
        $display("checks=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            final_report();
        end
    end
    initial
    begin
        {MODE, EXT_CTRL_MAP_ENABLE, REG_ADDR, REG_WR, REG_RD, REG_WDATA} = '0;
        {BUS_LOW_OUT, BUS_HIGH_OUT, BUS_DRIVE, CTRL_FUNC_OUT, xl, xh, xc} = '0;
        CTRL_FUNC_OE_N = 8'hff;
        void'($urandom(26104));
        rst();
        chk();
        repeat (6)
        begin
            {xl, xh, xc, CTRL_FUNC_OUT, CTRL_FUNC_OE_N} = {r8(), r8(), r8(), r8(), r8()};
            for (int a = 0; a < 14; a++)
                wr(4'(a), r8());
            repeat (3) @(negedge CLK);
            chk();
            rd(4'h0, 8'hff, (dl & ql) | ((xl | {8{pu[0]}}) & ~ql));
            rd(4'h1, 8'hff, (dh & qh) | ((xh | {8{pu[1]}}) & ~qh));
            rd(4'h2, 8'hff, ql);
            o = qc & ~asg & 8'hfc;
            rd(4'h8, ~asg | 8'h03, (dc & o) | ((xc | (pu[4] ? 8'h8f : 8'h00)) & ~o));
        end
        for (int m = 0; m < 8; m++)
        begin
            MODE = 2'(m);
            EXT_CTRL_MAP_ENABLE = m[2];
            BUS_DRIVE = m[0];
            {BUS_LOW_OUT, BUS_HIGH_OUT} = {r8(), r8()};
            wr(4'h2, r8());
            wr(4'h9, r8());
            rd(4'h2, 8'hff, hit(4'h2) ? ql : 8'h00);
            rd(4'h9, 8'hfc, hit(4'h9) ? qc : 8'h00);
            rd(4'h5, 8'hff, 8'h00);
            if (m[0])
            begin
                cmp(PIN_LOW_OUT, BUS_LOW_OUT);
                cmp(PIN_LOW_OE_N, 8'h00);
                cmp(PIN_HIGH_OUT, BUS_HIGH_OUT);
                cmp(PIN_HIGH_OE_N, 8'h00);
            end
        end
        {MODE, EXT_CTRL_MAP_ENABLE, BUS_DRIVE} = '0;
        repeat (3) @(negedge CLK);
        chk();
        rst();
        MODE = 2'h2;
        wr(4'hd, 8'hff);
        MODE = 2'h0;
        wr(4'hd, 8'h01);
        wr(4'hd, 8'h0a);
        wr(4'h2, 8'hff);
        wr(4'ha, 8'h00);
        wr(4'h9, 8'hfc);
        chk();
        final_report();
    end
endmodule

// *** hdl/bsgp_pin_cell.sv ***
// Per-port pin cell: output enable, pull and drive level
`timescale 1ns/1ps
module bsgp_pin_cell
(
    input wire logic [7:0] gpio_active,
    input wire logic [7:0] dir,
    input wire logic [7:0] out_data,
    input wire logic [7:0] func_oe_n,
    input wire logic [7:0] func_out,
    input wire logic [7:0] pull_mask,
    input wire logic pull_bit,
    input wire logic pull_allowed,
    input wire logic weak_bit,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output logic [7:0] pin_pull,
    output logic [7:0] pin_weak
);
    logic [7:0] drive;

    always_comb
    begin
        drive = (gpio_active & dir) | (~gpio_active & ~func_oe_n);
        pin_oe_n = ~drive;
        pin_out = (gpio_active & out_data) | (~gpio_active & func_out);
        pin_pull = (pull_bit && pull_allowed) ? (pull_mask & ~drive) : 8'h00;
        pin_weak = weak_bit ? drive : 8'h00;
    end
endmodule

// *** hdl/bsgp_pkg.sv ***
// Package with constants for the bus-shared port block
package bsgp_pkg;

    // ----------------------------------------
    // Register offsets (internal bus)
    // ----------------------------------------
    localparam logic [3:0] OFF_DATA_LOW = 4'h0;
    localparam logic [3:0] OFF_DATA_HIGH = 4'h1;
    localparam logic [3:0] OFF_DIR_LOW = 4'h2;
    localparam logic [3:0] OFF_DIR_HIGH = 4'h3;
    localparam logic [3:0] OFF_DATA_CTRL = 4'h8;
    localparam logic [3:0] OFF_DIR_CTRL = 4'h9;
    localparam logic [3:0] OFF_ASSIGN = 4'ha;
    localparam logic [3:0] OFF_PULL = 4'hc;
    localparam logic [3:0] OFF_REDUCE = 4'hd;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_PULL_LOW = 0;
    localparam int BIT_PULL_HIGH = 1;
    localparam int BIT_PULL_CTRL = 4;
    localparam int BIT_WEAK_LOW = 0;
    localparam int BIT_WEAK_HIGH = 1;
    localparam int BIT_WEAK_CTRL = 3;

    // ----------------------------------------
    // Reset values and masks
    // ----------------------------------------
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_ASSIGN = 8'h00;
    localparam logic [7:0] RST_PULL = 8'h00;
    localparam logic [7:0] RST_REDUCE = 8'h00;
    localparam logic [7:0] CTRL_DIR_MASK = 8'hfc;
    localparam logic [7:0] CTRL_PULL_MASK = 8'h8f;
    localparam logic [7:0] PULL_REG_MASK = 8'h13;
    localparam logic [7:0] REDUCE_REG_MASK = 8'h0b;

    // ----------------------------------------
    // Operating modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        BSGP_MODE_SINGLE = 2'h0,
        BSGP_MODE_EXPANDED = 2'h1,
        BSGP_MODE_PERIPH = 2'h2
    } bsgp_mode_t;

endpackage

// *** hdl/bsgp_ports.sv ***
// Bus-shared general-purpose ports: registers, visibility and pin control
`timescale 1ns/1ps
module bsgp_ports
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [1:0] MODE,
    input wire logic EXT_CTRL_MAP_ENABLE,
    input wire logic [3:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_HIT,
    input wire logic [7:0] BUS_LOW_OUT,
    input wire logic [7:0] BUS_HIGH_OUT,
    input wire logic BUS_DRIVE,
    input wire logic [7:0] CTRL_FUNC_OUT,
    input wire logic [7:0] CTRL_FUNC_OE_N,
    input wire logic [7:0] PIN_LOW_IN,
    output logic [7:0] PIN_LOW_OUT,
    output logic [7:0] PIN_LOW_OE_N,
    output logic [7:0] PIN_LOW_PULL,
    output logic [7:0] PIN_LOW_WEAK,
    input wire logic [7:0] PIN_HIGH_IN,
    output logic [7:0] PIN_HIGH_OUT,
    output logic [7:0] PIN_HIGH_OE_N,
    output logic [7:0] PIN_HIGH_PULL,
    output logic [7:0] PIN_HIGH_WEAK,
    input wire logic [7:0] PIN_CTRL_IN,
    output logic [7:0] PIN_CTRL_OUT,
    output logic [7:0] PIN_CTRL_OE_N,
    output logic [7:0] PIN_CTRL_PULL,
    output logic [7:0] PIN_CTRL_WEAK,
    output logic [7:0] BUS_LOW_IN,
    output logic [7:0] BUS_HIGH_IN,
    output logic MASKABLE_IRQ_IN_N,
    output logic NONMASKABLE_IRQ_IN_N
);

    // ----------------------------------------
    // Pin input synchronisers
    // ----------------------------------------
    logic [7:0] low_s1, low_s2, high_s1, high_s2, ctrl_s1, ctrl_s2;

    always_ff @(posedge CLK)
    begin
        low_s1 <= PIN_LOW_IN;
        low_s2 <= low_s1;
        high_s1 <= PIN_HIGH_IN;
        high_s2 <= high_s1;
        ctrl_s1 <= PIN_CTRL_IN;
        ctrl_s2 <= ctrl_s1;
    end

    assign BUS_LOW_IN = low_s2;
    assign BUS_HIGH_IN = high_s2;
    assign MASKABLE_IRQ_IN_N = ctrl_s2[1];
    assign NONMASKABLE_IRQ_IN_N = ctrl_s2[0];

    // ----------------------------------------
    // Mode decode and register visibility
    // ----------------------------------------
    logic single_chip, expanded, periph;
    logic bus_map, ctrl_map, reduce_map;

    assign single_chip = (MODE == bsgp_pkg::BSGP_MODE_SINGLE);
    assign periph = (MODE == bsgp_pkg::BSGP_MODE_PERIPH);
    assign expanded = !single_chip && !periph;
    assign bus_map = single_chip;
    assign ctrl_map = !periph && !(expanded && EXT_CTRL_MAP_ENABLE);
    assign reduce_map = !periph;

    logic hit_dlow, hit_dhigh, hit_rlow, hit_rhigh, hit_dctrl, hit_rctrl;
    logic hit_assign, hit_pull, hit_reduce;

    always_comb
    begin
        hit_dlow = bus_map && (REG_ADDR == bsgp_pkg::OFF_DATA_LOW);
        hit_dhigh = bus_map && (REG_ADDR == bsgp_pkg::OFF_DATA_HIGH);
        hit_rlow = bus_map && (REG_ADDR == bsgp_pkg::OFF_DIR_LOW);
        hit_rhigh = bus_map && (REG_ADDR == bsgp_pkg::OFF_DIR_HIGH);
        hit_dctrl = ctrl_map && (REG_ADDR == bsgp_pkg::OFF_DATA_CTRL);
        hit_rctrl = ctrl_map && (REG_ADDR == bsgp_pkg::OFF_DIR_CTRL);
        hit_assign = (REG_ADDR == bsgp_pkg::OFF_ASSIGN);
        hit_pull = (REG_ADDR == bsgp_pkg::OFF_PULL);
        hit_reduce = reduce_map && (REG_ADDR == bsgp_pkg::OFF_REDUCE);
    end

    assign REG_HIT = hit_dlow | hit_dhigh | hit_rlow | hit_rhigh | hit_dctrl
        | hit_rctrl | hit_assign | hit_pull | hit_reduce;

    // ----------------------------------------
    // Data registers
    // ----------------------------------------
    logic [7:0] data_low, data_high, data_ctrl;

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            data_low <= bsgp_pkg::RST_DATA;
            data_high <= bsgp_pkg::RST_DATA;
            data_ctrl <= bsgp_pkg::RST_DATA;
        end
        else if (REG_WR)
        begin
            if (hit_dlow)
                data_low <= REG_WDATA;
            if (hit_dhigh)
                data_high <= REG_WDATA;
            if (hit_dctrl)
                data_ctrl <= REG_WDATA;
        end
    end

    // ----------------------------------------
    // Direction registers
    // ----------------------------------------
    logic [7:0] dir_ctl_bus_low, dir_ctl_bus_high, dir_ctl_ctrl_port;

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            dir_ctl_bus_low <= bsgp_pkg::RST_DIR;
            dir_ctl_bus_high <= bsgp_pkg::RST_DIR;
            dir_ctl_ctrl_port <= bsgp_pkg::RST_DIR;
        end
        else if (REG_WR)
        begin
            if (hit_rlow)
                dir_ctl_bus_low <= REG_WDATA;
            if (hit_rhigh)
                dir_ctl_bus_high <= REG_WDATA;
            if (hit_rctrl)
                dir_ctl_ctrl_port <= REG_WDATA;
        end
    end

    // ----------------------------------------
    // Assignment, pull and reduce registers
    // ----------------------------------------
    logic [7:0] ctrl_port_assign_reg, pull_enable_reg, drive_reduce_reg;
    logic reduce_written;

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ctrl_port_assign_reg <= bsgp_pkg::RST_ASSIGN;
            pull_enable_reg <= bsgp_pkg::RST_PULL;
        end
        else if (REG_WR)
        begin
            if (hit_assign)
                ctrl_port_assign_reg <= REG_WDATA;
            if (hit_pull)
                pull_enable_reg <= REG_WDATA & bsgp_pkg::PULL_REG_MASK;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            drive_reduce_reg <= bsgp_pkg::RST_REDUCE;
            reduce_written <= 1'b0;
        end
        else if (REG_WR && hit_reduce && !reduce_written)
        begin
            drive_reduce_reg <= REG_WDATA & bsgp_pkg::REDUCE_REG_MASK;
            reduce_written <= 1'b1;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [7:0] pin_low_rd, pin_high_rd, pin_ctrl_rd, ctrl_dir_eff;

    always_comb
    begin
        pin_low_rd = (dir_ctl_bus_low & data_low) | (~dir_ctl_bus_low & low_s2);
        pin_high_rd = (dir_ctl_bus_high & data_high) | (~dir_ctl_bus_high & high_s2);
        pin_ctrl_rd = (ctrl_dir_eff & data_ctrl) | (~ctrl_dir_eff & ctrl_s2);
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            REG_RDATA <= 8'h00;
        else if (REG_RD)
        begin
            if (hit_dlow)
                REG_RDATA <= pin_low_rd;
            else if (hit_dhigh)
                REG_RDATA <= pin_high_rd;
            else if (hit_rlow)
                REG_RDATA <= dir_ctl_bus_low;
            else if (hit_rhigh)
                REG_RDATA <= dir_ctl_bus_high;
            else if (hit_dctrl)
                REG_RDATA <= pin_ctrl_rd;
            else if (hit_rctrl)
                REG_RDATA <= dir_ctl_ctrl_port;
            else if (hit_assign)
                REG_RDATA <= ctrl_port_assign_reg;
            else if (hit_pull)
                REG_RDATA <= pull_enable_reg;
            else if (hit_reduce)
                REG_RDATA <= drive_reduce_reg;
            else
                REG_RDATA <= 8'h00;
        end
    end

    // ----------------------------------------
    // Effective direction and function select
    // ----------------------------------------
    logic [7:0] ctrl_gpio, bus_gpio;
    logic [7:0] bus_oe_n;

    assign ctrl_dir_eff = dir_ctl_ctrl_port & bsgp_pkg::CTRL_DIR_MASK;
    assign ctrl_gpio = ~ctrl_port_assign_reg;
    assign bus_gpio = single_chip ? 8'hff : 8'h00;
    assign bus_oe_n = BUS_DRIVE ? 8'h00 : 8'hff;

    // ----------------------------------------
    // Pin cells
    // ----------------------------------------
    bsgp_pin_cell u_low
    (
        .gpio_active(bus_gpio),
        .dir(dir_ctl_bus_low),
        .out_data(data_low),
        .func_oe_n(bus_oe_n),
        .func_out(BUS_LOW_OUT),
        .pull_mask(8'hff),
        .pull_bit(pull_enable_reg[bsgp_pkg::BIT_PULL_LOW]),
        .pull_allowed(single_chip),
        .weak_bit(drive_reduce_reg[bsgp_pkg::BIT_WEAK_LOW]),
        .pin_out(PIN_LOW_OUT),
        .pin_oe_n(PIN_LOW_OE_N),
        .pin_pull(PIN_LOW_PULL),
        .pin_weak(PIN_LOW_WEAK)
    );

    bsgp_pin_cell u_high
    (
        .gpio_active(bus_gpio),
        .dir(dir_ctl_bus_high),
        .out_data(data_high),
        .func_oe_n(bus_oe_n),
        .func_out(BUS_HIGH_OUT),
        .pull_mask(8'hff),
        .pull_bit(pull_enable_reg[bsgp_pkg::BIT_PULL_HIGH]),
        .pull_allowed(single_chip),
        .weak_bit(drive_reduce_reg[bsgp_pkg::BIT_WEAK_HIGH]),
        .pin_out(PIN_HIGH_OUT),
        .pin_oe_n(PIN_HIGH_OE_N),
        .pin_pull(PIN_HIGH_PULL),
        .pin_weak(PIN_HIGH_WEAK)
    );

    bsgp_pin_cell u_ctrl
    (
        .gpio_active(ctrl_gpio | ~bsgp_pkg::CTRL_DIR_MASK),
        .dir(ctrl_dir_eff),
        .out_data(data_ctrl),
        .func_oe_n(CTRL_FUNC_OE_N | ~bsgp_pkg::CTRL_DIR_MASK),
        .func_out(CTRL_FUNC_OUT),
        .pull_mask(bsgp_pkg::CTRL_PULL_MASK),
        .pull_bit(pull_enable_reg[bsgp_pkg::BIT_PULL_CTRL]),
        .pull_allowed(1'b1),
        .weak_bit(drive_reduce_reg[bsgp_pkg::BIT_WEAK_CTRL]),
        .pin_out(PIN_CTRL_OUT),
        .pin_oe_n(PIN_CTRL_OE_N),
        .pin_pull(PIN_CTRL_PULL),
        .pin_weak(PIN_CTRL_WEAK)
    );

endmodule
